// ==== irpc_consts.vh ====
// Behaviour
// - Transmit: 16-bit modulo reloads, single-pass stops.
// - Demod: 16-bit captures every edge or first only.
// - 16-bit timeout flag sets; write one clears.
// - 16-bit interrupts gated by their enable bits.
// - Filtered, selected input gives edge pulses.
// - 8-bit output idles inverted, loads by level.
// - 8-bit single-pass: stop, toggle, flag, interrupt.
// - 8-bit modulo: toggle, reload; flag every second.
// - Reload writes apply only at next load.
// - Count one forbidden; zero wraps, no timeout.
// - 8-bit demod: capture complement per edge polarity.
// - 8-bit demod zero: flag, interrupt, keep counting.
// - 16-bit output idles inverted; submode forces level.
// - 16-bit enable loads upper*256+lower, toggles at zero.
// - 16-bit zero count wraps, not a timeout.
// - 16-bit demod edge: capture both, flag, restart at FFFF.
// - Single-pass demod: 8-bit timeout captures; rearm.
// - 16-bit demod zero: flag, interrupt, continue.
// - Ping-pong: timers alternate on terminal count.
// - Submode zero ends ping-pong; software starts it.
// - Mode bit: zero transmit, one demodulation.
// - Filter codes: none, 4, 8, 16 cycles.
// - Edge codes: falling, rising, both, reserved.
`ifndef IRPC_CONSTS_VH
`define IRPC_CONSTS_VH
// ==========================================================
// Register indices
`define IRPC_A_T8CTL  4'h0
`define IRPC_A_MODE   4'h1
`define IRPC_A_T16CTL 4'h2
`define IRPC_A_R8HI   4'h3
`define IRPC_A_R8LO   4'h4
`define IRPC_A_R16HI  4'h5
`define IRPC_A_R16LO  4'h6
`define IRPC_A_C8R    4'h7
`define IRPC_A_C8F    4'h8
`define IRPC_A_C16HI  4'h9
`define IRPC_A_C16LO  4'hA
// ==========================================================
// Timer control fields
`define IRPC_B_EN     7
`define IRPC_B_SPB    6
`define IRPC_B_TOUT   5
`define IRPC_B_CLKH   4
`define IRPC_B_CLKL   3
`define IRPC_B_CAPIE  2
`define IRPC_B_TOIE   1
`define IRPC_B_PIN    0
// ==========================================================
// Shared mode fields
`define IRPC_B_MODE   7
`define IRPC_B_INSEL  6
`define IRPC_B_EDGH   5
`define IRPC_B_EDGL   4
`define IRPC_B_SUBH   3
`define IRPC_B_SUBL   2
`define IRPC_B_INIT8  1
`define IRPC_B_INIT16 0
// ==========================================================
// Codes and values
`define IRPC_SUB_PP   2'h1
`define IRPC_EDG_FALL 2'h0
`define IRPC_EDG_RISE 2'h1
`define IRPC_EDG_BOTH 2'h2
`define IRPC_FLT_4    2'h1
`define IRPC_FLT_8    2'h2
`define IRPC_FLT_16   2'h3
`define IRPC_FW_1     5'h01
`define IRPC_FW_4     5'h04
`define IRPC_FW_8     5'h08
`define IRPC_FW_16    5'h10
`define IRPC_LOG_AND  2'h0
`define IRPC_LOG_OR   2'h1
`define IRPC_LOG_NOR  2'h2
`define IRPC_WRAP8    8'hFF
`define IRPC_WRAP16   16'hFFFF
`define IRPC_TC8      8'h01
`define IRPC_TC16     16'h0001
`define IRPC_RST8     8'h00
`define IRPC_RST16    16'h0000
`endif

// ==== irpc_edge_filter.v ====
`timescale 1ns/1ps
`include "irpc_consts.vh"
module irpc_edge_filter #(
    parameter CNT_W = 5
) (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       sig_in,
    input  wire [1:0] filt_sel,
    input  wire [1:0] edge_sel,
    output reg        pos_pulse,
    output reg        neg_pulse
);
    reg  [CNT_W-1:0] cnt_ff;
    reg              lvl_ff;
    reg  [CNT_W-1:0] need;
    wire [CNT_W-1:0] cnt_inc = cnt_ff + 1'b1;
    wire             flip    = (sig_in != lvl_ff) && (cnt_inc >= need);

    // ======================================================
    // Minimum width that a new level must hold.
    always @* begin
        case (filt_sel)
            `IRPC_FLT_4:  need = `IRPC_FW_4;
            `IRPC_FLT_8:  need = `IRPC_FW_8;
            `IRPC_FLT_16: need = `IRPC_FW_16;
            default:      need = `IRPC_FW_1;
        endcase
    end

    // ======================================================
    // A level change is accepted only after it has held for
    // the chosen width, so shorter glitches never reach the
    // counters; the price is that many cycles of latency.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff    <= {CNT_W{1'b0}};
            lvl_ff    <= 1'b0;
            pos_pulse <= 1'b0;
            neg_pulse <= 1'b0;
        end else begin
            if (flip || sig_in == lvl_ff) begin
                cnt_ff <= {CNT_W{1'b0}};
            end else begin
                cnt_ff <= cnt_inc;
            end
            if (flip) begin
                lvl_ff <= sig_in;
            end
            pos_pulse <= flip && sig_in &&
                (edge_sel == `IRPC_EDG_RISE ||
                 edge_sel == `IRPC_EDG_BOTH);
            neg_pulse <= flip && !sig_in &&
                (edge_sel == `IRPC_EDG_FALL ||
                 edge_sel == `IRPC_EDG_BOTH);
        end
    end
endmodule // irpc_edge_filter

// ==== irpc_top.v ====
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "irpc_consts.vh"
module irpc_top (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       demod_input_pin_a,
    input  wire       demod_input_pin_b,
    output reg        short_timer_output,
    output reg        long_timer_output,
    output reg        combined_output,
    output wire       combined_pin_select,
    output wire       pin_output_select,
    output reg        irq_t8,
    output reg        irq_t16
);
    // One-hot timer states.
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_RUN  = 3'b100;

    reg [7:0]  ctl8_ff, ctl16_ff, ctl1_ff;
    reg [7:0]  r8hi_ff, r8lo_ff, r16hi_ff, r16lo_ff;
    reg [7:0]  c8r_ff, c8f_ff, nxt_c8r, nxt_c8f;
    reg [15:0] c16_ff, nxt_c16;
    reg [2:0]  st8_ff, st16_ff, nxt_st8, nxt_st16;
    reg [7:0]  cnt8_ff, nxt_cnt8;
    reg [15:0] cnt16_ff, nxt_cnt16;
    reg        ph8_ff, nxt_ph8, arm_ff, nxt_arm;
    reg        to8_ff, to16_ff, nxt_to8, nxt_to16;
    reg        fr_ff, ff_ff, nxt_fr, nxt_ff;
    reg        nxt_out8, nxt_out16, nxt_irq8, nxt_irq16;
    reg        nxt_comb;
    reg [2:0]  div_ff;
    reg [7:0]  rd_val;

    // ======================================================
    // Decode and field views.
    wire wr_t8  = reg_wr && reg_addr == `IRPC_A_T8CTL;
    wire wr_md  = reg_wr && reg_addr == `IRPC_A_MODE;
    wire wr_t16 = reg_wr && reg_addr == `IRPC_A_T16CTL;
    wire demod  = ctl1_ff[`IRPC_B_MODE];
    wire [1:0] sub  = ctl1_ff[`IRPC_B_SUBH:`IRPC_B_SUBL];
    wire [1:0] edgs = ctl1_ff[`IRPC_B_EDGH:`IRPC_B_EDGL];
    wire init8  = ctl1_ff[`IRPC_B_INIT8];
    wire init16 = ctl1_ff[`IRPC_B_INIT16];
    wire spb8   = ctl8_ff[`IRPC_B_SPB];
    wire spb16  = ctl16_ff[`IRPC_B_SPB];
    wire pp     = !demod && sub == `IRPC_SUB_PP;
    wire frc16  = !demod && sub[1];
    wire [15:0] rel16 = {r16hi_ff, r16lo_ff};
    assign pin_output_select   = ctl16_ff[`IRPC_B_PIN];
    assign combined_pin_select = ctl1_ff[`IRPC_B_INSEL] && !demod;

    // ======================================================
    // Prescaler ticks; each timer picks its own division.
    function tick_of;
        input [1:0] sel;
        input [2:0] d;
        begin
            case (sel)
                2'h1:    tick_of = d[0];
                2'h2:    tick_of = &d[1:0];
                2'h3:    tick_of = &d;
                default: tick_of = 1'b1;
            endcase
        end
    endfunction
    wire tick8  = tick_of(ctl8_ff[`IRPC_B_CLKH:`IRPC_B_CLKL], div_ff);
    wire tick16 = tick_of(ctl16_ff[`IRPC_B_CLKH:`IRPC_B_CLKL],
                          div_ff);

    // ======================================================
    // Input edge detection.
    wire pos_e, neg_e;
    wire pin_in = ctl1_ff[`IRPC_B_INSEL] ? demod_input_pin_b
                                         : demod_input_pin_a;
    irpc_edge_filter #(.CNT_W(5)) u_edge (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .sig_in    (pin_in),
        .filt_sel  (sub),
        .edge_sel  (edgs),
        .pos_pulse (pos_e),
        .neg_pulse (neg_e)
    );
    wire edge_any = demod && (pos_e || neg_e);

    // ======================================================
    // Terminal counts fire on the tick that reaches zero, so a
    // loaded zero wraps to the top without a timeout.
    wire run8  = st8_ff == ST_RUN;
    wire run16 = st16_ff == ST_RUN;
    wire tc8  = run8 && tick8 && cnt8_ff == `IRPC_TC8;
    wire tc16 = run16 && tick16 && cnt16_ff == `IRPC_TC16;
    wire sw_go8   = wr_t8 && reg_wdata[`IRPC_B_EN] &&
                    st8_ff == ST_IDLE;
    wire sw_go16  = wr_t16 && reg_wdata[`IRPC_B_EN] &&
                    st16_ff == ST_IDLE;
    wire sw_stop8  = wr_t8 && !reg_wdata[`IRPC_B_EN];
    wire sw_stop16 = wr_t16 && !reg_wdata[`IRPC_B_EN];
    // Ping-pong handover: each single-pass finish starts the
    // other timer.
    wire go8  = sw_go8 || (pp && tc16 && spb16);
    wire go16 = sw_go16 || (pp && tc8 && spb8);

    // ======================================================
    // 8-bit timer next state.
    always @* begin
        nxt_st8  = st8_ff;
        nxt_cnt8 = cnt8_ff;
        nxt_out8 = short_timer_output;
        nxt_ph8  = ph8_ff;
        nxt_c8r  = c8r_ff;
        nxt_c8f  = c8f_ff;
        nxt_irq8 = 1'b0;
        // Write one clears; a set below still wins.
        nxt_to8  = to8_ff && !(wr_t8 && reg_wdata[`IRPC_B_TOUT]);
        if (run8 && tick8) begin
            nxt_cnt8 = cnt8_ff - 1'b1;
        end
        if (sw_stop8) begin
            nxt_st8 = ST_IDLE;
        end else if (go8) begin
            nxt_ph8 = 1'b0;
            if (demod) begin
                nxt_st8 = ST_WAIT;
            end else begin
                nxt_st8  = ST_RUN;
                nxt_out8 = init8;
                nxt_cnt8 = init8 ? r8hi_ff : r8lo_ff;
            end
        end else begin
            case (st8_ff)
                ST_IDLE: begin
                    if (!demod) begin
                        nxt_out8 = !init8;
                    end
                end
                ST_WAIT: begin
                    if (edge_any) begin
                        nxt_st8  = ST_RUN;
                        nxt_cnt8 = `IRPC_WRAP8;
                    end
                end
                ST_RUN: begin
                    if (demod) begin
                        if (tc8) begin
                            nxt_to8  = 1'b1;
                            nxt_irq8 = ctl8_ff[`IRPC_B_TOIE];
                        end
                        if (edge_any) begin
                            if (pos_e) begin
                                nxt_c8r = ~cnt8_ff;
                            end else begin
                                nxt_c8f = ~cnt8_ff;
                            end
                            nxt_cnt8 = `IRPC_WRAP8;
                            nxt_irq8 = nxt_irq8 ||
                                       ctl8_ff[`IRPC_B_CAPIE];
                        end
                    end else if (tc8) begin
                        nxt_out8 = !short_timer_output;
                        if (spb8) begin
                            nxt_st8  = ST_IDLE;
                            nxt_to8  = 1'b1;
                            nxt_irq8 = ctl8_ff[`IRPC_B_TOIE];
                        end else begin
                            nxt_ph8  = !ph8_ff;
                            nxt_cnt8 = short_timer_output ? r8lo_ff
                                                          : r8hi_ff;
                            if (ph8_ff) begin
                                nxt_to8  = 1'b1;
                                nxt_irq8 = ctl8_ff[`IRPC_B_TOIE];
                            end
                        end
                    end
                end
                default: nxt_st8 = ST_IDLE;
            endcase
        end
    end

    // ======================================================
    // 16-bit timer next state.
    always @* begin
        nxt_st16  = st16_ff;
        nxt_cnt16 = cnt16_ff;
        nxt_out16 = long_timer_output;
        nxt_c16   = c16_ff;
        nxt_irq16 = 1'b0;
        nxt_arm   = arm_ff;
        nxt_to16  = to16_ff &&
                    !(wr_t16 && reg_wdata[`IRPC_B_TOUT]);
        if (wr_t16 && reg_wdata[`IRPC_B_SPB] && !spb16) begin
            nxt_arm = 1'b1;
        end
        if (run16 && tick16) begin
            nxt_cnt16 = cnt16_ff - 1'b1;
        end
        if (sw_stop16) begin
            nxt_st16 = ST_IDLE;
        end else if (go16) begin
            if (demod) begin
                nxt_st16 = ST_WAIT;
                nxt_arm  = 1'b0;
            end else begin
                nxt_st16  = ST_RUN;
                nxt_out16 = init16;
                nxt_cnt16 = rel16;
            end
        end else begin
            case (st16_ff)
                ST_IDLE: begin
                    if (!demod) begin
                        nxt_out16 = !init16;
                    end
                end
                ST_WAIT: begin
                    if (edge_any) begin
                        nxt_st16  = ST_RUN;
                        nxt_cnt16 = rel16;
                    end
                end
                ST_RUN: begin
                    if (tc16) begin
                        nxt_to16  = 1'b1;
                        nxt_irq16 = ctl16_ff[`IRPC_B_TOIE];
                    end
                    if (demod) begin
                        if (edge_any && (!spb16 || arm_ff)) begin
                            nxt_c16   = ~cnt16_ff;
                            nxt_cnt16 = `IRPC_WRAP16;
                            nxt_arm   = 1'b0;
                            nxt_irq16 = nxt_irq16 ||
                                ctl16_ff[`IRPC_B_CAPIE];
                        end else if (spb16 && tc8) begin
                            nxt_c16   = ~cnt16_ff;
                            nxt_irq16 = nxt_irq16 ||
                                ctl16_ff[`IRPC_B_CAPIE];
                        end
                    end else if (tc16) begin
                        nxt_out16 = !long_timer_output;
                        if (spb16) begin
                            nxt_st16 = ST_IDLE;
                        end else begin
                            nxt_cnt16 = rel16;
                        end
                    end
                end
                default: nxt_st16 = ST_IDLE;
            endcase
        end
        // A forced level overrides the timer output at once.
        if (frc16) begin
            nxt_out16 = sub[0];
        end
    end

    // ======================================================
    // Edge flags and output combiner.
    always @* begin
        nxt_fr = (fr_ff && !(wr_md && reg_wdata[`IRPC_B_INIT8]))
                 || (edge_any && pos_e);
        nxt_ff = (ff_ff && !(wr_md && reg_wdata[`IRPC_B_INIT16]))
                 || (edge_any && neg_e);
        case (edgs)
            `IRPC_LOG_AND: nxt_comb = nxt_out8 & nxt_out16;
            `IRPC_LOG_OR:  nxt_comb = nxt_out8 | nxt_out16;
            `IRPC_LOG_NOR: nxt_comb = ~(nxt_out8 | nxt_out16);
            default:       nxt_comb = ~(nxt_out8 & nxt_out16);
        endcase
    end

    // ======================================================
    // Read mux; enable and flag bits show live state.
    always @* begin
        case (reg_addr)
            `IRPC_A_T8CTL:  rd_val = {st8_ff != ST_IDLE,
                                      ctl8_ff[6], to8_ff,
                                      ctl8_ff[4:0]};
            `IRPC_A_MODE:   rd_val = demod ?
                                     {ctl1_ff[7:2], fr_ff, ff_ff} :
                                     ctl1_ff;
            `IRPC_A_T16CTL: rd_val = {st16_ff != ST_IDLE,
                                      ctl16_ff[6], to16_ff,
                                      ctl16_ff[4:0]};
            `IRPC_A_R8HI:   rd_val = r8hi_ff;
            `IRPC_A_R8LO:   rd_val = r8lo_ff;
            `IRPC_A_R16HI:  rd_val = r16hi_ff;
            `IRPC_A_R16LO:  rd_val = r16lo_ff;
            `IRPC_A_C8R:    rd_val = c8r_ff;
            `IRPC_A_C8F:    rd_val = c8f_ff;
            `IRPC_A_C16HI:  rd_val = c16_ff[15:8];
            `IRPC_A_C16LO:  rd_val = c16_ff[7:0];
            default:        rd_val = `IRPC_RST8;
        endcase
    end

    // ======================================================
    // Software-written registers.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl8_ff  <= `IRPC_RST8;
            ctl16_ff <= `IRPC_RST8;
            ctl1_ff  <= `IRPC_RST8;
            r8hi_ff  <= `IRPC_RST8;
            r8lo_ff  <= `IRPC_RST8;
            r16hi_ff <= `IRPC_RST8;
            r16lo_ff <= `IRPC_RST8;
        end else if (reg_wr) begin
            case (reg_addr)
                `IRPC_A_T8CTL:  ctl8_ff  <= reg_wdata;
                `IRPC_A_T16CTL: ctl16_ff <= reg_wdata;
                // Initial levels stay put while flags are cleared.
                `IRPC_A_MODE:   ctl1_ff  <= reg_wdata[`IRPC_B_MODE] ?
                                {reg_wdata[7:2], ctl1_ff[1:0]} :
                                reg_wdata;
                `IRPC_A_R8HI:   r8hi_ff  <= reg_wdata;
                `IRPC_A_R8LO:   r8lo_ff  <= reg_wdata;
                `IRPC_A_R16HI:  r16hi_ff <= reg_wdata;
                `IRPC_A_R16LO:  r16lo_ff <= reg_wdata;
                default:        ctl1_ff  <= ctl1_ff;
            endcase
        end
    end

    // ======================================================
    // Timer state, captures, outputs and read data.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st8_ff             <= ST_IDLE;
            st16_ff            <= ST_IDLE;
            cnt8_ff            <= `IRPC_RST8;
            cnt16_ff           <= `IRPC_RST16;
            ph8_ff             <= 1'b0;
            arm_ff             <= 1'b0;
            to8_ff             <= 1'b0;
            to16_ff            <= 1'b0;
            fr_ff              <= 1'b0;
            ff_ff              <= 1'b0;
            c8r_ff             <= `IRPC_RST8;
            c8f_ff             <= `IRPC_RST8;
            c16_ff             <= `IRPC_RST16;
            div_ff             <= 3'h0;
            short_timer_output <= 1'b0;
            long_timer_output  <= 1'b0;
            combined_output    <= 1'b0;
            irq_t8             <= 1'b0;
            irq_t16            <= 1'b0;
            reg_rdata          <= `IRPC_RST8;
        end else begin
            st8_ff             <= nxt_st8;
            st16_ff            <= nxt_st16;
            cnt8_ff            <= nxt_cnt8;
            cnt16_ff           <= nxt_cnt16;
            ph8_ff             <= nxt_ph8;
            arm_ff             <= nxt_arm;
            to8_ff             <= nxt_to8;
            to16_ff            <= nxt_to16;
            fr_ff              <= nxt_fr;
            ff_ff              <= nxt_ff;
            c8r_ff             <= nxt_c8r;
            c8f_ff             <= nxt_c8f;
            c16_ff             <= nxt_c16;
            div_ff             <= div_ff + 3'h1;
            short_timer_output <= nxt_out8;
            long_timer_output  <= nxt_out16;
            combined_output    <= nxt_comb;
            irq_t8             <= nxt_irq8;
            irq_t16            <= nxt_irq16;
            reg_rdata          <= reg_rd ? rd_val : `IRPC_RST8;
        end
    end
endmodule // irpc_top

// ==== irpc_checker_properties.sv ====
`timescale 1ns/1ps
// ==========================================================
// Port checker: ties the block's outputs to the register writes.
module irpc_checker (
    input wire       clk_sys,
    input wire       rst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       short_timer_output,
    input wire       long_timer_output,
    input wire       combined_pin_select,
    input wire       pin_output_select,
    input wire       irq_t8,
    input wire       irq_t16
);
    reg  [7:0] mode_ff;
    reg  [7:0] ctl8_ff;
    reg  [7:0] ctl16_ff;
    wire       idle_tx;
    wire       wr_mode;
    // Shadow copies of the control bytes, so enables are known here.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= 8'h00;
            ctl8_ff <= 8'h00;
            ctl16_ff <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 4'h1) mode_ff <= reg_wdata;
            if (reg_addr == 4'h0) ctl8_ff <= reg_wdata;
            if (reg_addr == 4'h2) ctl16_ff <= reg_wdata;
        end
    end
    // Starts are only judged in plain transmit, where no hand-over occurs.
    assign idle_tx = !mode_ff[7] && mode_ff[3:2] == 2'h0;
    assign wr_mode = reg_wr && reg_addr == 4'h1 && !reg_wdata[7];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_force_low;
        wr_mode && reg_wdata[3:2] == 2'h2 |-> ##[1:2] !long_timer_output;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("long output not forced low");
    property p_force_high;
        wr_mode && reg_wdata[3:2] == 2'h3 |-> ##[1:2] long_timer_output;
    endproperty
    a_force_high: assert property (p_force_high)
        else $error("long output not forced high");
    property p_start8;
        reg_wr && reg_addr == 4'h0 && reg_wdata[7] && idle_tx
        && short_timer_output != mode_ff[1]
        |-> ##[1:2] short_timer_output == mode_ff[1];
    endproperty
    a_start8: assert property (p_start8)
        else $error("short output did not take initial level");
    property p_start16;
        reg_wr && reg_addr == 4'h2 && reg_wdata[7] && idle_tx
        && long_timer_output != mode_ff[0]
        |-> ##[1:2] long_timer_output == mode_ff[0];
    endproperty
    a_start16: assert property (p_start16)
        else $error("long output did not take initial level");
    property p_irq16_gate;
        irq_t16 |-> ctl16_ff[2] || ctl16_ff[1];
    endproperty
    a_irq16_gate: assert property (p_irq16_gate)
        else $error("long interrupt while disabled");
    property p_irq8_gate;
        irq_t8 |-> ctl8_ff[2] || ctl8_ff[1];
    endproperty
    a_irq8_gate: assert property (p_irq8_gate)
        else $error("short interrupt while disabled");
    property p_comb_sel;
        combined_pin_select == (mode_ff[6] && !mode_ff[7]);
    endproperty
    a_comb_sel: assert property (p_comb_sel)
        else $error("combined select wrong");
    property p_pin_sel;
        pin_output_select == ctl16_ff[0];
    endproperty
    a_pin_sel: assert property (p_pin_sel)
        else $error("pin select wrong");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
endmodule // irpc_checker
bind irpc_top irpc_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .short_timer_output(short_timer_output),
    .long_timer_output(long_timer_output),
    .combined_pin_select(combined_pin_select),
    .pin_output_select(pin_output_select), .irq_t8(irq_t8),
    .irq_t16(irq_t16));

// ==== irpc_source.sv ====
`timescale 1ns/1ps
// ==========================================================
// Far-side pulse source feeding the demodulator input pins.
module irpc_source (
    input  wire clk_sys,
    output reg  pin_a,
    output reg  pin_b
);
    // Pin b rests at its pulled-up level; only pin a carries pulses.
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b1;
    end
    // One pulse: high for hi cycles, then low for lo cycles.
    task pulse(input int hi, input int lo);
        @(posedge clk_sys);
        pin_a <= 1'b1;
        repeat (hi) @(posedge clk_sys);
        pin_a <= 1'b0;
        repeat (lo) @(posedge clk_sys);
    endtask
endmodule // irpc_source

// ==== irpc_top_test.sv ====
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the pulse counter block.
module irpc_top_test;
    reg        clk_sys = 1'b0;
    reg        rst_n = 1'b0;
    reg  [3:0] reg_addr = 4'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    reg  [7:0] d;
    reg        o8_q = 1'b0;
    wire [7:0] reg_rdata;
    wire       pin_a, pin_b, out8, out16, psel, irq_t8, irq_t16, comb;
    int        fails = 0, comparisons = 0, n8 = 0, n16 = 0, tg8 = 0;
    always #10 clk_sys = ~clk_sys;
    irpc_source u_src (.clk_sys(clk_sys), .pin_a(pin_a), .pin_b(pin_b));
    irpc_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .demod_input_pin_a(pin_a),
        .demod_input_pin_b(pin_b), .short_timer_output(out8),
        .long_timer_output(out16), .combined_output(comb),
        .combined_pin_select(), .pin_output_select(psel),
        .irq_t8(irq_t8), .irq_t16(irq_t16));
    // Interrupt pulses and short-output toggles, counted.
    always @(posedge clk_sys) begin
        if (irq_t8 === 1'b1) n8++;
        if (irq_t16 === 1'b1) n16++;
        if (out8 !== o8_q) tg8++;
        o8_q <= out8;
    end
    task ck(input [15:0] got, input [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [3:0] a, input [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rd(input [3:0] a, output [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task run(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task end_of_test;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task t_single8;
        wr(4'h1, 8'h00); wr(4'h4, 8'h03); run(1); ck(out8, 1);
        n8 = 0; wr(4'h0, 8'hC2); run(2); ck(out8, 0);
        run(20); ck(out8, 1); ck(n8[15:0], 1);
        rd(4'h0, d); ck(d, 8'h62);
        wr(4'h0, 8'h62); rd(4'h0, d); ck(d, 8'h42);
        rd(4'hF, d); ck(d, 8'h00);
    endtask
    task t_mod8;
        wr(4'h3, 8'h03); n8 = 0; wr(4'h0, 8'h82); tg8 = 0; run(60);
        ck((tg8 - 1) / 2, n8[15:0]); ck(tg8 >= 4, 1);
        wr(4'h0, 8'h02); wr(4'h0, 8'h20);
    endtask
    task t_single16;
        wr(4'h5, 8'h00); wr(4'h6, 8'h06); run(1); ck(out16, 1);
        n16 = 0; wr(4'h2, 8'hC3); run(2); ck(out16, 0); ck(psel, 1);
        run(30); ck(out16, 1); ck(n16[15:0], 1);
        rd(4'h2, d); ck(d, 8'h63); wr(4'h2, 8'h43); rd(4'h2, d);
        ck(d, 8'h63); wr(4'h2, 8'h63); rd(4'h2, d); ck(d, 8'h43);
    endtask
    task t_force;
        wr(4'h1, 8'h18); run(2); ck(out16, 0); ck(comb, 1);
        wr(4'h1, 8'h2C); run(2); ck(out16, 1); ck(comb, 0);
        wr(4'h1, 8'h00);
    endtask
    task t_pp;
        wr(4'h1, 8'h04); wr(4'h2, 8'h42); n8 = 0; n16 = 0;
        wr(4'h0, 8'hC2); run(40); ck(n8[15:0], 5); ck(n16[15:0], 4);
        wr(4'h1, 8'h00);
    endtask
    task t_demod16;
        wr(4'h5, 8'hFF); wr(4'h6, 8'hFF); wr(4'h1, 8'h90);
        n16 = 0; wr(4'h2, 8'h84); repeat (3) u_src.pulse(10, 30);
        run(3); ck(n16[15:0], 2);
        rd(4'hA, d); ck(d >= 36 && d <= 44, 1);
        wr(4'h2, 8'hC4); n16 = 0; repeat (2) u_src.pulse(10, 30);
        run(3); ck(n16[15:0], 1);
        wr(4'h2, 8'h84); wr(4'h1, 8'h9C); n16 = 0;
        repeat (2) u_src.pulse(8, 40); ck(n16[15:0], 0);
        repeat (2) u_src.pulse(20, 40); run(20); ck(n16[15:0], 2);
        wr(4'h2, 8'h04); wr(4'h2, 8'h24); wr(4'h1, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_single8; t_mod8; t_single16; t_force; t_pp; t_demod16;
        end_of_test;
    end
    // A hang is counted as a failure.
    initial begin
        #400000;
        fails++;
        end_of_test;
    end
endmodule // irpc_top_test
